// *** bench/tas_pad.sv ***
// Purpose: Strap pad tied low, floating or tied high
// Assumes: st 0 ground, 1 floating, 2 supply
// Notes:   A floating pad follows the weak pull the device applies
`timescale 1ns/100ps
`default_nettype none
module tas_pad (
	input  wire logic       pu_en,
	input  wire logic [1:0] st,
	output logic            pin
);
	assign pin = (st == 2'h1) ? pu_en : st[1];
endmodule
`default_nettype wire

// *** bench/tas_status_bank_asserts.sv ***
// Purpose: Port checks of the status bank
// Assumes: Four remote channels
// Notes:   A flag shows in the byte two edges after its event
`timescale 1ns/100ps
`default_nettype none
module tas_chk (
	input wire logic       mclk,
	input wire logic       rst_n,
	input wire logic       conv_busy,
	input wire logic       conv_start,
	input wire logic       ondie_over,
	input wire logic       ondie_under,
	input wire logic       diode_open,
	input wire logic [3:0] remote_over,
	input wire logic       rd_sel,
	input wire logic [7:0] rd_data_q,
	input wire logic [6:0] slave_addr_q,
	input wire logic       addr_valid_q
);
	default clocking @(posedge mclk);
	endclocking
	default disable iff (!rst_n);
	a_busy_live: assert property (
		!rd_sel |=> rd_data_q[7] == $past(conv_busy)) else $error("busy bit");
	a_low_zero: assert property (
		!rd_sel |=> rd_data_q[2:0] == 3'h0) else $error("low bits");
	a_over_set: assert property (
		ondie_over && !rd_sel ##1 !rd_sel |=> rd_data_q[6]) else $error("over flag");
	a_under_set: assert property (
		ondie_under && !rd_sel ##1 !rd_sel |=> rd_data_q[5]) else $error("under flag");
	a_open_set: assert property (
		conv_start && diode_open && !rd_sel ##1 !rd_sel |=> rd_data_q[4]) else $error("open");
	a_alarm_or: assert property (
		(|remote_over) && !rd_sel ##1 !rd_sel |=> rd_data_q[3]) else $error("alarm");
	a_ch1_over: assert property (
		remote_over[0] && rd_sel ##1 rd_sel |=> rd_data_q[6]) else $error("ch1 over");
	a_addr_held: assert property (
		addr_valid_q |=> addr_valid_q && $stable(slave_addr_q)) else $error("addr moved");
endmodule
bind tas_status_bank tas_chk i_chk (.mclk, .rst_n, .conv_busy, .conv_start, .ondie_over,
	.ondie_under, .diode_open, .remote_over, .rd_sel, .rd_data_q, .slave_addr_q, .addr_valid_q);
`default_nettype wire

// *** bench/tas_status_bank_tb_top.sv ***
// Purpose: Self-checking bench of the status bank
// Assumes: Inputs change on the falling edge
// Notes:   One reset per strap pair since straps are read once
`timescale 1ns/100ps
`default_nettype none
module tas_status_bank_tb_top;
	logic mclk = 1'b0, rst_n = 1'b0, conv_busy = 1'b0, conv_start = 1'b0, diode_open = 1'b0;
	logic ondie_over = 1'b0, ondie_under = 1'b0, rd_sel = 1'b0, rd_done = 1'b0;
	logic [3:0] remote_over = 4'h0, remote_under = 4'h0;
	logic [1:0] sa = 2'h0, sb = 2'h0;
	wire logic addr_strap_a, addr_strap_b, strap_a_pu_en, strap_b_pu_en, addr_valid_q;
	wire logic [7:0] rd_data_q;
	wire logic [6:0] slave_addr_q;
	int bad_count = 0, tests_run = 0;
	always #5 mclk = ~mclk;
	tas_status_bank i_dut (.mclk, .rst_n, .conv_busy, .conv_start, .ondie_over, .ondie_under,
		.diode_open, .remote_over, .remote_under, .rd_sel, .rd_done, .addr_strap_a,
		.addr_strap_b, .strap_a_pu_en, .strap_b_pu_en, .rd_data_q, .slave_addr_q, .addr_valid_q);
	tas_pad i_pa (.pu_en(strap_a_pu_en), .st(sa), .pin(addr_strap_a));
	tas_pad i_pb (.pu_en(strap_b_pu_en), .st(sb), .pin(addr_strap_b));
	task automatic step(input int n);
		repeat (n) @(negedge mclk);
	endtask
	task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH %s exp %h got %h", nm, exp, got);
		end
	endtask
	task automatic rd(input logic s, input logic [7:0] exp);
		rd_sel = s;
		step(2);
		chk("status", exp, rd_data_q);
	endtask
	task automatic clr(input logic s);
		rd_sel = s;
		rd_done = 1'b1;
		step(1);
		rd_done = 1'b0;
		step(2);
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial begin
		#100000;
		bad_count++;
		report_and_stop();
	end
	initial begin
		for (int a = 0; a < 3; a++) for (int b = 0; b < 3; b++) begin
			sa = a[1:0];
			sb = b[1:0];
			rst_n = 1'b0;
			step(12);
			rst_n = 1'b1;
			for (int k = 0; k < 40 && addr_valid_q !== 1'b1; k++) step(1);
			chk("addr", {1'b0, a == 0 ? 4'h3 : a == 1 ? 4'h5 : 4'h9,
				3'(b + (a == 2 ? 4 : a))}, {1'b0, slave_addr_q});
		end
		sa = 2'h0;
		step(20);
		chk("addr", 8'h4e, {1'b0, slave_addr_q});
		rd(1'b0, 8'h00);
		conv_busy = 1'b1;
		rd(1'b0, 8'h80);
		conv_busy = 1'b0;
		ondie_over = 1'b1;
		step(1);
		ondie_over = 1'b0;
		step(5);
		rd(1'b0, 8'h40);
		clr(1'b0);
		rd(1'b0, 8'h00);
		ondie_under = 1'b1;
		remote_under = 4'h2;
		conv_start = 1'b1;
		diode_open = 1'b1;
		step(1);
		ondie_under = 1'b0;
		remote_under = 4'h0;
		conv_start = 1'b0;
		rd(1'b0, 8'h38);
		rd(1'b1, 8'h20);
		clr(1'b1);
		rd(1'b1, 8'h00);
		clr(1'b0);
		rd(1'b0, 8'h10);
		diode_open = 1'b0;
		clr(1'b0);
		rd(1'b0, 8'h10);
		conv_start = 1'b1;
		step(1);
		conv_start = 1'b0;
		clr(1'b0);
		rd(1'b0, 8'h00);
		for (int i = 0; i < 4; i++) begin
			remote_over = 4'h1 << i;
			remote_under = 4'h1 << i;
			step(1);
			remote_over = 4'h0;
			remote_under = 4'h0;
			rd(1'b1, 8'hc0 >> (2 * i));
			clr(1'b1);
		end
		report_and_stop();
	end
endmodule
`default_nettype wire

// *** src/tas_flag_cell.v ***
// Purpose: One sticky alarm flag cleared by status read unless still active
// Assumes: Event and read strobe are on mclk
// Notes:   Set wins over the read clear so no event is lost
`timescale 1ns/100ps
`default_nettype none
module tas_flag_cell (
	input  wire mclk,
	input  wire rst_n,
	input  wire event_in,
	input  wire rd_clr,
	output reg  flag_q
);
	always @(posedge mclk) begin
		if (!rst_n)
			flag_q <= 1'b0;
		else if (event_in)
			flag_q <= 1'b1;
		else if (rd_clr)
			flag_q <= 1'b0;
	end
endmodule
`default_nettype wire

// *** src/tas_map.vh ***
// Purpose: Constants for the temperature status flag bank and address decode
// Assumes: Included by the status bank and strap sense design files
// Notes:   Bit positions count from the least significant bit
`ifndef TAS_MAP_VH
`define TAS_MAP_VH

`define TAS_B1_BUSY        7
`define TAS_B1_ONDIE_OVER  6
`define TAS_B1_ONDIE_UNDER 5
`define TAS_B1_OPEN        4
`define TAS_B1_ALARM       3
`define TAS_B1_RESET       8'h00
`define TAS_B2_RESET       8'h00
`define TAS_SEL_PRIMARY    1'b0
`define TAS_SEL_REMOTE     1'b1
`define TAS_STRAP_GND      2'h0
`define TAS_STRAP_FLOAT    2'h1
`define TAS_STRAP_VCC      2'h2
`define TAS_ADDR_HI_GND    4'h3
`define TAS_ADDR_HI_FLOAT  4'h5
`define TAS_ADDR_HI_VCC    4'h9
`define TAS_ADDR_RESET     7'h00

`endif

// *** src/tas_status_bank.v ***
// Purpose: Status flag bytes and strapped slave address of a temperature monitor
// Assumes: Alarm inputs come from same-clock converter logic; straps are pins
// Notes:   Read strobe marks a completed bus read of the selected byte
// Operation
// - primary bit 7 follows converter busy
// - primary bit 6 sets on on-die over-limit
// - primary bit 5 sets on on-die under-limit
// - primary bit 4 sets on remote open fault
// - primary bit 3 ORs all remote alarms
// - primary bits 6-3 sticky until reset or read
// - remote bit 7/6 channel one under/over
// - remote bit 5/4 channel two under/over
// - remote bit 3/2 channel three, absent two-remote
// - remote bit 1/0 channel four, absent two-remote
// - remote flags sticky until reset or read
// - two straps decode nine slave addresses
// - floating strap is a distinct third state
// - read clears flags unless fault persists
// - straps sampled only after reset, then held
// - open flag refreshed only at conversion start
`timescale 1ns/100ps
`default_nettype none
`include "tas_map.vh"
module tas_status_bank #(
	parameter FOUR_REMOTE = 1
) (
	input  wire       mclk,
	input  wire       rst_n,
	input  wire       conv_busy,
	input  wire       conv_start,
	input  wire       ondie_over,
	input  wire       ondie_under,
	input  wire       diode_open,
	input  wire [3:0] remote_over,
	input  wire [3:0] remote_under,
	input  wire       rd_sel,
	input  wire       rd_done,
	input  wire       addr_strap_a,
	input  wire       addr_strap_b,
	output wire       strap_a_pu_en,
	output wire       strap_b_pu_en,
	output reg  [7:0] rd_data_q,
	output reg  [6:0] slave_addr_q,
	output reg        addr_valid_q
);
	wire [1:0] st_a;
	wire [1:0] st_b;
	wire       clr_pri;
	wire       clr_rem;
	wire       f_over;
	wire       f_under;
	wire       f_alarm;
	reg        open_q;
	reg        open_live_q;
	reg        done_q;
	reg  [3:0] settle_q;
	wire [7:0] remote_flags;
	wire [7:0] remote_events;
	wire [7:0] primary_byte;
	reg  [3:0] addr_hi;
	reg  [2:0] addr_lo;

	assign clr_pri = rd_done && (rd_sel == `TAS_SEL_PRIMARY);
	assign clr_rem = rd_done && (rd_sel == `TAS_SEL_REMOTE);

	// Persisting faults re-set in the clear cycle, as set beats clear
	tas_flag_cell u_over (
		.mclk     (mclk),
		.rst_n    (rst_n),
		.event_in (ondie_over),
		.rd_clr   (clr_pri),
		.flag_q   (f_over)
	);
	tas_flag_cell u_under (
		.mclk     (mclk),
		.rst_n    (rst_n),
		.event_in (ondie_under),
		.rd_clr   (clr_pri),
		.flag_q   (f_under)
	);
	tas_flag_cell u_alarm (
		.mclk     (mclk),
		.rst_n    (rst_n),
		.event_in (|(remote_events)),
		.rd_clr   (clr_pri),
		.flag_q   (f_alarm)
	);

	// Open fault is only looked at when a conversion starts
	always @(posedge mclk) begin
		if (!rst_n) begin
			open_q      <= 1'b0;
			open_live_q <= 1'b0;
		end else begin
			if (conv_start)
				open_live_q <= diode_open;
			if (conv_start && diode_open)
				open_q <= 1'b1;
			else if (clr_pri && !open_live_q)
				open_q <= 1'b0;
		end
	end

	genvar ch;
	generate
		for (ch = 0; ch < 4; ch = ch + 1) begin : g_ch
			// Channel ch occupies bits 7-2*ch (under) and 6-2*ch (over)
			wire present = (ch < 2) || (FOUR_REMOTE != 0);
			assign remote_events[7-2*ch] = present & remote_under[ch];
			assign remote_events[6-2*ch] = present & remote_over[ch];
			tas_flag_cell u_lo (
				.mclk     (mclk),
				.rst_n    (rst_n),
				.event_in (remote_events[7-2*ch]),
				.rd_clr   (clr_rem),
				.flag_q   (remote_flags[7-2*ch])
			);
			tas_flag_cell u_hi (
				.mclk     (mclk),
				.rst_n    (rst_n),
				.event_in (remote_events[6-2*ch]),
				.rd_clr   (clr_rem),
				.flag_q   (remote_flags[6-2*ch])
			);
		end
	endgenerate

	assign primary_byte = {conv_busy, f_over, f_under, open_q, f_alarm, 3'h0};

	always @(posedge mclk) begin
		if (!rst_n)
			rd_data_q <= `TAS_B1_RESET;
		else if (rd_sel == `TAS_SEL_PRIMARY)
			rd_data_q <= primary_byte;
		else
			rd_data_q <= remote_flags;
	end

	tas_strap_sense u_sa (
		.mclk    (mclk),
		.rst_n   (rst_n),
		.pin_in  (addr_strap_a),
		.pu_en   (strap_a_pu_en),
		.state_q (st_a)
	);
	tas_strap_sense u_sb (
		.mclk    (mclk),
		.rst_n   (rst_n),
		.pin_in  (addr_strap_b),
		.pu_en   (strap_b_pu_en),
		.state_q (st_b)
	);

	// Strap a picks the upper nibble and base, strap b adds 0..2
	always @* begin
		case (st_a)
			`TAS_STRAP_FLOAT: begin
				addr_hi = `TAS_ADDR_HI_FLOAT;
				addr_lo = 3'h1;
			end
			`TAS_STRAP_VCC: begin
				addr_hi = `TAS_ADDR_HI_VCC;
				addr_lo = 3'h4;
			end
			default: begin
				addr_hi = `TAS_ADDR_HI_GND;
				addr_lo = 3'h0;
			end
		endcase
		addr_lo = addr_lo + {1'b0, st_b};
	end

	// Sense finishes once after reset; the address is then frozen.
	// The pull-down phase lasts eight edges and the strap state is only
	// resolved near its end, so wait it out before latching the address.
	always @(posedge mclk) begin
		if (!rst_n) begin
			done_q       <= 1'b0;
			settle_q     <= 4'h0;
			addr_valid_q <= 1'b0;
			slave_addr_q <= `TAS_ADDR_RESET;
		end else begin
			if (!strap_a_pu_en && !strap_b_pu_en && settle_q != 4'hf)
				settle_q <= settle_q + 4'h1;
			done_q <= (settle_q >= 4'h8);
			if (done_q && !addr_valid_q) begin
				slave_addr_q <= {addr_hi, addr_lo};
				addr_valid_q <= 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// *** src/tas_strap_sense.v ***
// Purpose: Resolve one three-state strap pin into ground, floating or supply
// Assumes: The pad drives a weak pull-up then a weak pull-down through pu_en
// Notes:   Pin levels pass three flops; a level counts once stages two and three agree
`timescale 1ns/100ps
`default_nettype none
`include "tas_map.vh"
module tas_strap_sense (
	input  wire       mclk,
	input  wire       rst_n,
	input  wire       pin_in,
	output wire       pu_en,
	output reg  [1:0] state_q
);
	reg  [2:0] sync_q;
	reg  [3:0] cnt_q;
	reg        hi_pu_q;
	wire       stable;

	// Pull up for the first half of the window, pull down for the second
	assign pu_en  = ~cnt_q[3];
	assign stable = (sync_q[1] == sync_q[2]);

	always @(posedge mclk) begin
		if (!rst_n) begin
			sync_q  <= 3'h0;
			cnt_q   <= 4'h0;
			hi_pu_q <= 1'b0;
			state_q <= `TAS_STRAP_GND;
		end else begin
			sync_q <= {sync_q[1:0], pin_in};
			if (cnt_q != 4'hf)
				cnt_q <= cnt_q + 4'h1;
			if (cnt_q == 4'h7 && stable)
				hi_pu_q <= sync_q[2];
			// A pin that follows both pulls is floating
			if (cnt_q == 4'he && stable) begin
				if (hi_pu_q && !sync_q[2])
					state_q <= `TAS_STRAP_FLOAT;
				else if (hi_pu_q)
					state_q <= `TAS_STRAP_VCC;
				else
					state_q <= `TAS_STRAP_GND;
			end
		end
	end
endmodule
`default_nettype wire
